// [verilog/sbg_baud_gen.sv]
// Implementation choices: the plain strobed port and the register addresses.
`include "sbg_cfg.svh"
// Function
// RQ1: baud is module clock over sixteen times divisor; tick marks one sixteenth.
// RQ2: divisor is 13 bits: high byte bits 4..0, low byte 7..0.
// RQ3: high byte write is staged; commits with the next low byte write.
// RQ4: reads after lone high write may be stale until low byte written.
// RQ5: both divisor bytes readable and writable at any time.
// RQ6: generator stopped after reset until tx or rx enable first set.
// RQ7: no ticks while the divisor is zero.
// RQ8: one-cycle tick every divisor clocks; count restarts on divisor commit.
module sbg_baud_gen
	import sbg_pkg::*;
#(
	parameter int DIV_W = 13
) (
	// clock and reset
	clk,
	rst_n,
	// register port
	addr,
	wdata,
	wr,
	rd,
	rdata,
	// serial logic side
	tx_on_bit,
	rx_on_bit,
	baud_tick
);
	input wire logic clk;
	input wire logic rst_n;
	input wire logic [1:0] addr;
	input wire logic [7:0] wdata;
	input wire logic wr;
	input wire logic rd;
	output logic [7:0] rdata;
	output logic tx_on_bit;
	output logic rx_on_bit;
	output logic baud_tick;

	typedef struct packed {
		logic [`SBG_HIGH_BITS-1:0] stage;
		logic [DIV_W-1:0] baud_divisor;
		logic tx_on;
		logic rx_on;
		sbg_mode_type mode;
		logic restart;
		logic [7:0] rdata;
		logic tick;
	} sbg_state_type;

	sbg_state_type state_r;
	sbg_state_type state_nxt;
	logic cnt_tick;

	if (DIV_W != 13) begin : g_div_w_check
		$error("DIV_W must be 13");
	end

	sbg_tick_counter #(.DIV_W(DIV_W)) u_cnt (
		.clk(clk),
		.rst_n(rst_n),
		.run(state_r.mode == SBG_RUNNING),
		.restart(state_r.restart),
		.divisor_value(state_r.baud_divisor),
		.tick(cnt_tick)
	);

	always_comb begin
		state_nxt = state_r;
		state_nxt.restart = 1'b0;
		state_nxt.rdata = 8'h00;
		state_nxt.tick = cnt_tick;
		if (wr) begin // see RQ5
			unique case (addr)
				`SBG_ADDR_HIGH: state_nxt.stage = wdata[`SBG_HIGH_BITS-1:0]; // see RQ3
				`SBG_ADDR_LOW: begin
					state_nxt.baud_divisor = {state_r.stage, wdata}; // see RQ2 see RQ3
					state_nxt.restart = 1'b1; // see RQ8
				end
				`SBG_ADDR_CTRL: begin
					state_nxt.tx_on = wdata[`SBG_TX_ON_POS];
					state_nxt.rx_on = wdata[`SBG_RX_ON_POS];
				end
				`SBG_ADDR_STAT: ;
			endcase
		end
		if (state_nxt.tx_on || state_nxt.rx_on) begin
			state_nxt.mode = SBG_RUNNING; // see RQ6
		end
		if (rd) begin // see RQ4 see RQ5
			unique case (addr)
				`SBG_ADDR_HIGH: state_nxt.rdata = {3'h0, state_r.baud_divisor[DIV_W-1:8]};
				`SBG_ADDR_LOW: state_nxt.rdata = state_r.baud_divisor[7:0];
				`SBG_ADDR_CTRL: state_nxt.rdata = {6'h00, state_r.rx_on, state_r.tx_on};
				`SBG_ADDR_STAT: state_nxt.rdata = {7'h00, state_r.mode == SBG_RUNNING};
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '{stage: '0, baud_divisor: `SBG_DIV_RST, tx_on: 1'b0,
				rx_on: 1'b0, mode: SBG_STOPPED, restart: 1'b0, rdata: 8'h00, tick: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rdata = state_r.rdata;
	assign tx_on_bit = state_r.tx_on;
	assign rx_on_bit = state_r.rx_on;
	assign baud_tick = state_r.tick;

	// tick never while stopped
	stopped_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		(state_r.mode == SBG_STOPPED) |-> ##2 !baud_tick)
		else $error("tick while stopped");

	zero_div_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ7
		(state_r.baud_divisor == '0) [*3] |-> !baud_tick)
		else $error("tick with zero divisor");

	low_commit_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ3
		(wr && addr == `SBG_ADDR_LOW) |=>
			state_r.baud_divisor == {$past(state_r.stage), $past(wdata)})
		else $error("divisor not committed");

	high_staged_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ3
		(wr && addr == `SBG_ADDR_HIGH) |=> $stable(state_r.baud_divisor))
		else $error("high write changed divisor");

	read_low_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		(rd && addr == `SBG_ADDR_LOW) |=> rdata == $past(state_r.baud_divisor[7:0]))
		else $error("low read wrong");

	sequence tick_seen;
		baud_tick;
	endsequence
	tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ8
		(tick_seen and (state_r.baud_divisor == 13'h0003 && !state_r.restart
			&& !$past(state_r.restart)))
		##1 ((state_r.baud_divisor == 13'h0003) && !state_r.restart && !wr) [*3]
		|-> baud_tick)
		else $error("tick spacing wrong");

	tick_single_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ1
		(baud_tick && state_r.baud_divisor > 13'h0001 && !state_r.restart) |=> !baud_tick)
		else $error("tick longer than a cycle");

	run_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		(state_r.mode == SBG_RUNNING) |=> (state_r.mode == SBG_RUNNING))
		else $error("generator stopped again");

	// register port requests
	sequence high_write_s;
		wr && addr == `SBG_ADDR_HIGH;
	endsequence

	sequence low_write_s;
		wr && addr == `SBG_ADDR_LOW;
	endsequence

	sequence ctrl_write_s;
		wr && addr == `SBG_ADDR_CTRL;
	endsequence

	sequence stat_write_s;
		wr && addr == `SBG_ADDR_STAT;
	endsequence

	sequence enable_write_s;
		wr && addr == `SBG_ADDR_CTRL
			&& wdata[`SBG_RX_ON_POS:`SBG_TX_ON_POS] != 2'h0;
	endsequence

	sequence high_read_s;
		rd && addr == `SBG_ADDR_HIGH;
	endsequence

	sequence ctrl_read_s;
		rd && addr == `SBG_ADDR_CTRL;
	endsequence

	sequence stat_read_s;
		rd && addr == `SBG_ADDR_STAT;
	endsequence

	// commit of divisor three while running, then an undisturbed count
	sequence commit_three_s;
		state_r.restart && state_r.baud_divisor == 13'h0003
			&& state_r.mode == SBG_RUNNING;
	endsequence

	sequence count_quiet_s;
		(!state_r.restart && state_r.baud_divisor == 13'h0003) [*4];
	endsequence

	stage_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ3
		high_write_s
		|=> state_r.stage == $past(wdata[`SBG_HIGH_BITS-1:0]))
		else $error("high byte not staged");

	stage_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ3
		!(wr && addr == `SBG_ADDR_HIGH)
		|=> $stable(state_r.stage))
		else $error("stage changed without write");

	divisor_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ3
		!(wr && addr == `SBG_ADDR_LOW)
		|=> $stable(state_r.baud_divisor))
		else $error("divisor changed without low write");

	restart_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ8
		low_write_s
		|=> state_r.restart)
		else $error("no restart on commit");

	restart_only_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ8
		!(wr && addr == `SBG_ADDR_LOW)
		|=> !state_r.restart)
		else $error("restart without commit");

	restart_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ8
		(state_r.restart && state_r.mode == SBG_RUNNING)
		|-> ##2 !baud_tick)
		else $error("tick right after restart");

	first_tick_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ8
		commit_three_s ##1 count_quiet_s
		|=> baud_tick)
		else $error("first tick after commit late");

	ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		ctrl_write_s
		|=> tx_on_bit == $past(wdata[`SBG_TX_ON_POS])
			&& rx_on_bit == $past(wdata[`SBG_RX_ON_POS]))
		else $error("enable bits not written");

	ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		!(wr && addr == `SBG_ADDR_CTRL)
		|=> $stable(tx_on_bit) && $stable(rx_on_bit))
		else $error("enable bits changed without write");

	stat_ignored_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		stat_write_s
		|=> $stable(state_r.baud_divisor) && $stable(state_r.stage))
		else $error("status write had effect");

	enable_start_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		enable_write_s
		|=> state_r.mode == SBG_RUNNING)
		else $error("enable did not start generator");

	stopped_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		(state_r.mode == SBG_STOPPED && !(wr && addr == `SBG_ADDR_CTRL
			&& wdata[`SBG_RX_ON_POS:`SBG_TX_ON_POS] != 2'h0))
		|=> state_r.mode == SBG_STOPPED)
		else $error("generator started without enable");

	tick_needs_run_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		baud_tick
		|-> $past(state_r.mode == SBG_RUNNING, 2))
		else $error("tick without run");

	tick_needs_div_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ7
		baud_tick
		|-> $past(state_r.baud_divisor != '0, 2))
		else $error("tick from zero divisor");

	read_high_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ4
		high_read_s
		|=> rdata == {3'h0, $past(state_r.baud_divisor[DIV_W-1:8])})
		else $error("high read wrong");

	read_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		ctrl_read_s
		|=> rdata == {6'h00, $past(rx_on_bit), $past(tx_on_bit)})
		else $error("control read wrong");

	read_stat_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ6
		stat_read_s
		|=> rdata == {7'h00, $past(state_r.mode == SBG_RUNNING)})
		else $error("status read wrong");

	rdata_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // see RQ5
		!rd
		|=> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule : sbg_baud_gen

// [verilog/sbg_cfg.svh]
`ifndef SBG_CFG_SVH
`define SBG_CFG_SVH
`define SBG_ADDR_HIGH 2'h0
`define SBG_ADDR_LOW 2'h1
`define SBG_ADDR_CTRL 2'h2
`define SBG_ADDR_STAT 2'h3
`define SBG_HIGH_BITS 5
`define SBG_DIV_RST 13'h0000
`define SBG_TX_ON_POS 0
`define SBG_RX_ON_POS 1
`define SBG_OVERSAMPLE 16
`endif

// [verilog/sbg_pkg.sv]
package sbg_pkg;
	typedef enum logic [1:0] {
		SBG_STOPPED,
		SBG_RUNNING
	} sbg_mode_type;
endpackage : sbg_pkg

// [verilog/sbg_tick_counter.sv]
`include "sbg_cfg.svh"
// free count to divisor, one-cycle tick at terminal count
module sbg_tick_counter
	import sbg_pkg::*;
#(
	parameter int DIV_W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic restart,
	input wire logic [DIV_W-1:0] divisor_value,
	// tick
	output logic tick
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} sbg_cnt_type;

	sbg_cnt_type state_r;
	sbg_cnt_type state_nxt;

	if (DIV_W < 2) begin : g_div_w_check
		$error("DIV_W too small");
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.tick = 1'b0;
		if (!run || restart || divisor_value == '0) begin // see RQ7 see RQ8
			state_nxt.cnt = '0;
		end else if (state_r.cnt >= divisor_value - 1'b1) begin // see RQ1 see RQ8
			state_nxt.cnt = '0;
			state_nxt.tick = 1'b1;
		end else begin
			state_nxt.cnt = state_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign tick = state_r.tick;
endmodule : sbg_tick_counter

// [verif/sbg_serial_model.sv]
// serial side: counts ticks and the spacing between them
module sbg_serial_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// tick in
	input wire logic baud_tick,
	// measured
	output logic [15:0] gap,
	output logic [15:0] ticks
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			gap <= 16'h0000;
			ticks <= 16'h0000;
		end else if (baud_tick) begin
			gap <= cnt + 16'h0001;
			cnt <= 16'h0000;
			ticks <= ticks + 16'h0001;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule : sbg_serial_model

// [verif/tb_sbg_baud_gen.sv]
`include "sbg_cfg.svh"
module tb_sbg_baud_gen;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic tx_on_bit, rx_on_bit, baud_tick;
	logic [15:0] gap, ticks;
	int mismatches = 0, comparisons = 0;
	initial forever #25 clk = ~clk;
	sbg_baud_gen #(.DIV_W(13)) i_sbg_baud_gen (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_on_bit(tx_on_bit),
		.rx_on_bit(rx_on_bit), .baud_tick(baud_tick));
	sbg_serial_model i_sbg_serial_model (.clk(clk), .rst_n(rst_n), .baud_tick(baud_tick),
		.gap(gap), .ticks(ticks));
	task finish_test;
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
		end
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask : wr_reg
	task rd_chk(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk) begin
			addr <= a;
			rd <= 1'b1;
		end
		@(posedge clk) rd <= 1'b0;
		#1 chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask : rd_chk
	task idle(input int n);
		logic [15:0] t;
		#1;
		t = ticks;
		repeat (n) @(posedge clk);
		#1 chk("no ticks", t, ticks);
	endtask : idle
	task wait_ticks(input int n);
		logic [15:0] t;
		t = ticks + n[15:0];
		for (int i = 0; i < 200 && ticks < t; i++) @(posedge clk) #1;
		if (ticks < t) begin
			chk("tick wait", t, ticks);
			finish_test();
		end
	endtask : wait_ticks
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wr_reg(`SBG_ADDR_LOW, 8'h03);
		idle(40);
		rd_chk(`SBG_ADDR_LOW, 8'h03);
		$display("test stopped done");
		wr_reg(`SBG_ADDR_CTRL, 8'h03);
		chk("ctrl", 16'h0003, {14'h0000, rx_on_bit, tx_on_bit});
		wait_ticks(3);
		chk("gap", 16'h0003, gap);
		$display("test run done");
		wr_reg(`SBG_ADDR_HIGH, 8'hff);
		rd_chk(`SBG_ADDR_HIGH, 8'h00);
		wait_ticks(2);
		chk("gap", 16'h0003, gap);
		wr_reg(`SBG_ADDR_LOW, 8'h02);
		rd_chk(`SBG_ADDR_HIGH, 8'h1f);
		wr_reg(`SBG_ADDR_HIGH, 8'h00);
		wr_reg(`SBG_ADDR_LOW, 8'h04);
		wait_ticks(3);
		chk("gap", 16'h0004, gap);
		$display("test staging done");
		wr_reg(`SBG_ADDR_LOW, 8'h00);
		repeat (2) @(posedge clk);
		idle(30);
		$display("test zero done");
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(`SBG_ADDR_STAT, 8'h00);
		wr_reg(`SBG_ADDR_LOW, 8'h03);
		idle(20);
		wr_reg(`SBG_ADDR_CTRL, 8'h02);
		chk("ctrl", 16'h0002, {14'h0000, rx_on_bit, tx_on_bit});
		rd_chk(`SBG_ADDR_STAT, 8'h01);
		wr_reg(`SBG_ADDR_LOW, 8'h03);
		wait_ticks(3);
		chk("gap", 16'h0003, gap);
		wr_reg(`SBG_ADDR_CTRL, 8'h00);
		rd_chk(`SBG_ADDR_CTRL, 8'h00);
		rd_chk(`SBG_ADDR_STAT, 8'h01);
		wait_ticks(2);
		chk("gap", 16'h0003, gap);
		$display("test reset done");
		finish_test();
	end
endmodule : tb_sbg_baud_gen
